// ---- shared/tsoc_pkg.sv ----
package tsoc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CHAIN_MASTER_BIT = 1;
  localparam int CTRL_DIVERSITY_BIT = 2;
  localparam int CTRL_APPEND_BIT = 3;
  localparam int CTRL_DIV_LSB = 4;
  localparam int DIV_W = 4;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LOADED_BIT = 4;
  localparam int STAT_OWN_BIT = 5;
  localparam int STAT_BUS_MASTER_BIT = 6;
  localparam int STAT_APPEND_PEND_BIT = 7;

  // Interrupt event bits
  localparam int IRQ_LOADED_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_OVERRUN_BIT = 2;
  localparam int N_IRQ = 3;
  localparam logic [N_IRQ-1:0] IRQ_RST = 3'h0;

  // Data-valid pulse lengths in processing clocks
  localparam logic [2:0] DV_CYC_SINGLE = 3'h2;
  localparam logic [2:0] DV_CYC_DIVERSITY = 3'h4;

  // Words per frame share
  localparam int WORDS_SINGLE = 2;
  localparam int WORDS_DIVERSITY = 4;
  localparam int WORDS_MAX = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_ARMED = 2'b10,
    ST_SHIFT = 2'b11
  } tsoc_state_t;

endpackage

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, psel, penable, pwrite, sv, rv, bms, fe_up, run, go, clr;
  logic pready, pslverr, re, sclk, sclk_oe, fs, fe, sdl, sdl_oe, dv, irq, msclk, mfs;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [63:0] sd;
  logic [15:0] rd;
  logic [79:0] bits;
  int cnt, error_cnt, compares;
  tsoc_chain DUT (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sample_data(sd), .i_sample_valid(sv),
    .i_ctrl_read_data(rd), .i_ctrl_read_valid(rv), .i_bus_master_select(bms),
    .i_serial_clock(msclk), .i_frame_start_strobe(mfs), .i_upstream_frame_end_strobe(fe_up),
    .o_serial_clock(sclk), .o_serial_clock_oe(sclk_oe), .o_frame_start_strobe(fs),
    .o_frame_end_strobe(fe), .o_serial_data_out_line(sdl),
    .o_serial_data_out_line_oe(sdl_oe), .o_output_data_valid(dv), .o_irq(irq));
  tsoc_dsp_model #(.HALF(8)) u_dsp (.i_clk(clk), .i_run(run), .i_go(go), .i_clr(clr),
    .i_dev_clk_sel(bms), .i_dev_sclk(sclk), .i_data(sdl), .i_data_oe(sdl_oe),
    .o_sclk(msclk), .o_fs(mfs), .o_bits(bits), .o_cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo;
    $display("wrong value at %0t: wait ran out", $time);
    error_cnt++;
    summarize();
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) tmo();
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic load(input logic [63:0] d, input int dvn);
    int n;
    int e;
    logic p;
    n = 0;
    e = 0;
    p = 1'b0;
    sd <= d;
    sv <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    clr <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (dv === 1'b1) n++;
      if (dv === 1'b1 && p === 1'b0) e++;
      p = dv;
    end
    chk(n, dvn);
    chk(e, 1);
    @(posedge clk);
  endtask
  task automatic tog(input int exp);
    int n;
    logic p;
    n = 0;
    @(negedge clk);
    p = sclk;
    repeat (16) begin
      @(negedge clk);
      if (sclk !== p) n++;
      p = sclk;
    end
    chk(n, exp);
    @(posedge clk);
  endtask
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (cnt != n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 4000) tmo();
    repeat (60) @(posedge clk);
    chk(cnt, n);
  endtask
  task automatic t_regs;
    apb(1'b0, tsoc_pkg::CTRL_OFS, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({re, rq}, 33'h100000000);
    apb(1'b0, tsoc_pkg::IRQ_CLR_OFS, 32'h0);
    chk(rq, 32'h0);
  endtask
  task automatic t_single;
    bms <= 1'b1;
    apb(1'b1, tsoc_pkg::CTRL_OFS, 32'h3);
    repeat (4) @(posedge clk);
    load(64'h0123_4567_89ab_cdef, 2);
    tog(16);
    chk(sclk_oe, 1'b1);
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    wait_bits(32);
    chk(bits[31:0], 32'h89ab_cdef);
    apb(1'b0, tsoc_pkg::IRQ_STAT_OFS, 32'h0);
    chk(rq, 32'h7);
    chk(irq, 1'b0);
    apb(1'b1, tsoc_pkg::IRQ_EN_OFS, 32'h2);
    apb(1'b0, tsoc_pkg::IRQ_EN_OFS, 32'h0);
    chk({irq, rq}, 33'h100000002);
    apb(1'b1, tsoc_pkg::IRQ_CLR_OFS, 32'h7);
    apb(1'b0, tsoc_pkg::IRQ_STAT_OFS, 32'h0);
    chk({irq, rq}, 33'h0);
  endtask
  task automatic t_div;
    apb(1'b1, tsoc_pkg::CTRL_OFS, 32'h27);
    load(64'hfedc_ba98_7654_3210, 4);
    tog(8);
    wait_bits(64);
    chk(bits[63:0], 64'hfedc_ba98_7654_3210);
  endtask
  task automatic t_slave;
    bms <= 1'b0;
    run <= 1'b1;
    apb(1'b1, tsoc_pkg::CTRL_OFS, 32'h1);
    rd <= 16'h5a3c;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    load(64'h1111_2222_3333_4444, 2);
    chk(sclk_oe, 1'b0);
    repeat (40) @(posedge clk);
    chk(sdl_oe, 1'b0);
    apb(1'b0, tsoc_pkg::STATUS_OFS, 32'h0);
    chk(rq, 32'h12);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_bits(48);
    chk(bits[47:0], 48'h3333_4444_5a3c);
    // Append select on with no read pending: held word goes out again
    apb(1'b1, tsoc_pkg::CTRL_OFS, 32'h9);
    load(64'h5555_6666_7777_8888, 2);
    fe_up <= 1'b1;
    repeat (16) @(posedge clk);
    fe_up <= 1'b0;
    wait_bits(48);
    chk(bits[47:0], 48'h7777_8888_5a3c);
    run <= 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, sv, rv, bms, fe_up, run, go} = 9'h0;
    clr = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    sd = 64'h0;
    rd = 16'h0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    @(posedge clk);
    t_regs();
    t_single();
    t_div();
    t_slave();
    summarize();
  end
endmodule
`default_nettype wire

// ---- tb/tsoc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsoc_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sample_valid,
  input wire logic i_bus_master_select,
  input wire logic o_serial_clock_oe,
  input wire logic o_frame_start_strobe,
  input wire logic o_frame_end_strobe,
  input wire logic o_serial_data_out_line_oe,
  input wire logic o_output_data_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_dv_len;
    $rose(o_output_data_valid) |-> (o_output_data_valid[*2] ##1 !o_output_data_valid)
      or (o_output_data_valid[*4] ##1 !o_output_data_valid);
  endproperty
  a_dv_len: assert property (p_dv_len) else $error("valid pulse length");
  property p_dv_cause;
    $rose(o_output_data_valid) |-> $past(i_sample_valid);
  endproperty
  a_dv_cause: assert property (p_dv_cause) else $error("valid without sample");
  property p_fs_idle;
    o_frame_start_strobe |-> !o_serial_data_out_line_oe;
  endproperty
  a_fs_idle: assert property (p_fs_idle) else $error("drive during start");
  property p_fs_then;
    $fell(o_frame_start_strobe) |-> o_serial_data_out_line_oe;
  endproperty
  a_fs_then: assert property (p_fs_then) else $error("no drive after start");
  property p_fe_own;
    o_frame_end_strobe |-> o_serial_data_out_line_oe;
  endproperty
  a_fe_own: assert property (p_fe_own) else $error("end outside own bits");
  property p_fe_end;
    $rose(o_frame_end_strobe) |-> ##[1:64] ($fell(o_frame_end_strobe) && !o_serial_data_out_line_oe);
  endproperty
  a_fe_end: assert property (p_fe_end) else $error("line kept after end");
  property p_oe_drop;
    $fell(o_serial_data_out_line_oe) |-> $past(o_frame_end_strobe);
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("line dropped early");
  property p_sclk_oe;
    (!i_bus_master_select)[*8] |-> !o_serial_clock_oe;
  endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("clock driven as slave");
endmodule
bind tsoc_chain tsoc_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_sample_valid(i_sample_valid), .i_bus_master_select(i_bus_master_select),
  .o_serial_clock_oe(o_serial_clock_oe), .o_frame_start_strobe(o_frame_start_strobe),
  .o_frame_end_strobe(o_frame_end_strobe), .o_output_data_valid(o_output_data_valid),
  .o_serial_data_out_line_oe(o_serial_data_out_line_oe));
`default_nettype wire

// ---- tb/tsoc_dsp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsoc_dsp_model #(
  parameter int HALF = 8
) (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_go,
  input wire logic i_clr,
  input wire logic i_dev_clk_sel,
  input wire logic i_dev_sclk,
  input wire logic i_data,
  input wire logic i_data_oe,
  output logic o_sclk,
  output logic o_fs,
  output logic [79:0] o_bits,
  output int o_cnt
);
  int div;
  logic fs_req;
  logic seen;
  logic use_clk;
  assign use_clk = i_dev_clk_sel ? i_dev_sclk : o_sclk;
  // Host clock runs free while enabled, framing starts on a rise
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      o_sclk <= 1'b0;
      o_fs <= 1'b0;
      fs_req <= 1'b0;
      div <= 0;
    end else begin
      div <= (div == HALF - 1) ? 0 : div + 1;
      if (div == HALF - 1) begin
        o_sclk <= ~o_sclk;
        if (!o_sclk) begin
          o_fs <= fs_req;
          fs_req <= 1'b0;
        end
      end
      // Set after the clear, so a request on a rising toggle is kept
      if (i_go) fs_req <= 1'b1;
    end
  end
  // Taken on the falling edge and only while driven, so no stale word is read
  always_ff @(posedge i_clk) begin
    seen <= use_clk;
    if (i_clr) begin
      o_bits <= '0;
      o_cnt <= 0;
    end else if (seen && !use_clk && i_data_oe) begin
      o_bits <= {o_bits[78:0], i_data};
      o_cnt <= o_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tsoc_chain.sv ----
// Functional notes
// - The chain master, or a slave started by the outside frame start strobe, drives the shared data line first in a frame.
// - A chain master holding loaded output words raises frame start to announce the data.
// - After frame start the chain master drives the data line and shifts its words bit by bit.
// - The chain master raises frame end together with its final bit.
// - A chained slave that sees the upstream frame end takes the line on the next serial cycle.
// - Each slave raises its own frame end with its last bit so the next device can follow.
// - After the last frame end the frame is complete and no more bits are driven.
// - Data valid pulses high for two or four processing clocks when a new sample is ready.
// - As bus master the serial clock is the clock divided by two times the 4-bit word, zero halving it.
// - The bus-master select pin decides who makes the serial clock; otherwise the word is ignored.
// - Pending register read data is appended to the frame whatever the append select says.
`timescale 1ns/1ps
`default_nettype none
module tsoc_chain #(
  parameter int WORD_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [4*WORD_W-1:0] i_sample_data,
  input wire logic i_sample_valid,
  input wire logic [WORD_W-1:0] i_ctrl_read_data,
  input wire logic i_ctrl_read_valid,
  input wire logic i_bus_master_select,
  input wire logic i_serial_clock,
  input wire logic i_frame_start_strobe,
  input wire logic i_upstream_frame_end_strobe,
  output logic o_serial_clock,
  output logic o_serial_clock_oe,
  output logic o_frame_start_strobe,
  output logic o_frame_end_strobe,
  output logic o_serial_data_out_line,
  output logic o_serial_data_out_line_oe,
  output logic o_output_data_valid,
  output logic o_irq
);

  localparam int SH_W = tsoc_pkg::WORDS_MAX * WORD_W;
  localparam int CNT_W = $clog2(SH_W + 1);

  logic [tsoc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [tsoc_pkg::N_IRQ-1:0] irq_stat_reg;
  logic [tsoc_pkg::N_IRQ-1:0] irq_en_reg;
  logic [tsoc_pkg::N_IRQ-1:0] irq_ev;
  logic [tsoc_pkg::N_IRQ-1:0] irq_clr;
  tsoc_pkg::tsoc_state_t state_reg;
  logic [SH_W-1:0] sh_reg;
  logic [SH_W-1:0] sh_next;
  logic [CNT_W-1:0] total_reg;
  logic [CNT_W-1:0] total_next;
  logic [CNT_W-1:0] bitcnt_reg;
  logic loaded_reg;
  logic start_pend_reg;
  logic app_pend_reg;
  logic [WORD_W-1:0] app_data_reg;
  logic [2:0] dv_cnt_reg;
  logic [2:0] bm_sync_reg;
  logic [1:0] fs_sync_reg;
  logic [1:0] fe_sync_reg;
  logic tick_rise;
  logic tick_fall;
  logic sclk;
  logic ctl_en;
  logic ctl_master;
  logic ctl_div_mode;
  logic ctl_append;
  logic load;
  logic take_app;
  logic frame_done;
  logic access;
  logic wr;
  logic rd;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign ctl_en = ctrl_reg[tsoc_pkg::CTRL_EN_BIT];
  assign ctl_master = ctrl_reg[tsoc_pkg::CTRL_CHAIN_MASTER_BIT];
  assign ctl_div_mode = ctrl_reg[tsoc_pkg::CTRL_DIVERSITY_BIT];
  assign ctl_append = ctrl_reg[tsoc_pkg::CTRL_APPEND_BIT];

  // Pins from outside are synchronised before any logic looks at them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bm_sync_reg <= 3'h0;
      fs_sync_reg <= 2'h0;
      fe_sync_reg <= 2'h0;
    end else begin
      bm_sync_reg <= {bm_sync_reg[1:0], i_bus_master_select};
      fs_sync_reg <= {fs_sync_reg[0], i_frame_start_strobe};
      fe_sync_reg <= {fe_sync_reg[0], i_upstream_frame_end_strobe};
    end
  end

  tsoc_sclk_gen #(
    .DIV_W(tsoc_pkg::DIV_W)
  ) u_sclk_gen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_gen_en(bm_sync_reg[1]),
    .i_div(ctrl_reg[tsoc_pkg::CTRL_DIV_LSB +: tsoc_pkg::DIV_W]),
    .i_ext_sclk(i_serial_clock),
    .o_sclk(sclk),
    .o_tick_rise(tick_rise),
    .o_tick_fall(tick_fall)
  );

  // Serial clock driven only when this device is the bus master
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_serial_clock <= 1'b0;
      o_serial_clock_oe <= 1'b0;
    end else begin
      o_serial_clock <= sclk;
      o_serial_clock_oe <= bm_sync_reg[2];
    end
  end

  // New samples are only taken while the shifter is empty
  assign load = i_sample_valid & ctl_en & ~loaded_reg;
  assign take_app = ctl_append | app_pend_reg;

  always_comb begin
    sh_next = '0;
    total_next = '0;
    if (ctl_div_mode) begin
      sh_next[SH_W-1 -: 4*WORD_W] = i_sample_data;
      sh_next[WORD_W-1:0] = app_data_reg;
      total_next = CNT_W'(tsoc_pkg::WORDS_DIVERSITY * WORD_W);
    end else begin
      sh_next[SH_W-1 -: 2*WORD_W] = i_sample_data[2*WORD_W-1:0];
      sh_next[SH_W-2*WORD_W-1 -: WORD_W] = app_data_reg;
      total_next = CNT_W'(tsoc_pkg::WORDS_SINGLE * WORD_W);
    end
    if (take_app) begin
      total_next = total_next + CNT_W'(WORD_W);
    end
  end

  // Register read data waits here for the next frame; a new read wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      app_pend_reg <= 1'b0;
      app_data_reg <= '0;
    end else if (i_ctrl_read_valid) begin
      app_pend_reg <= 1'b1;
      app_data_reg <= i_ctrl_read_data;
    end else if (load) begin
      app_pend_reg <= 1'b0;
    end
  end

  // Data valid pulse length follows the channel mode
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dv_cnt_reg <= 3'h0;
      o_output_data_valid <= 1'b0;
    end else if (load) begin
      dv_cnt_reg <= ctl_div_mode ? tsoc_pkg::DV_CYC_DIVERSITY - 3'h1
                                 : tsoc_pkg::DV_CYC_SINGLE - 3'h1;
      o_output_data_valid <= 1'b1;
    end else if (dv_cnt_reg != 3'h0) begin
      dv_cnt_reg <= dv_cnt_reg - 3'h1;
    end else begin
      o_output_data_valid <= 1'b0;
    end
  end

  assign frame_done = (state_reg == tsoc_pkg::ST_SHIFT) && tick_rise && (bitcnt_reg == total_reg);

  // Frame sequencer; the line changes only on serial clock rising ticks
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= tsoc_pkg::ST_IDLE;
      sh_reg <= '0;
      total_reg <= '0;
      bitcnt_reg <= '0;
      loaded_reg <= 1'b0;
      start_pend_reg <= 1'b0;
      o_frame_start_strobe <= 1'b0;
      o_frame_end_strobe <= 1'b0;
      o_serial_data_out_line <= 1'b0;
      o_serial_data_out_line_oe <= 1'b0;
    end else begin
      if (load) begin
        sh_reg <= sh_next;
        total_reg <= total_next;
        loaded_reg <= 1'b1;
      end
      case (state_reg)
        tsoc_pkg::ST_IDLE: begin
          o_serial_data_out_line_oe <= 1'b0;
          start_pend_reg <= 1'b0;
          if (loaded_reg && ctl_en) begin
            if (ctl_master) begin
              if (tick_rise) begin
                o_frame_start_strobe <= 1'b1;
                state_reg <= tsoc_pkg::ST_SYNC;
              end
            end else begin
              state_reg <= tsoc_pkg::ST_ARMED;
            end
          end
        end
        tsoc_pkg::ST_SYNC: begin
          if (tick_rise) begin
            o_frame_start_strobe <= 1'b0;
            o_serial_data_out_line_oe <= 1'b1;
            o_serial_data_out_line <= sh_reg[SH_W-1];
            sh_reg <= {sh_reg[SH_W-2:0], 1'b0};
            bitcnt_reg <= CNT_W'(1);
            state_reg <= tsoc_pkg::ST_SHIFT;
          end
        end
        tsoc_pkg::ST_ARMED: begin
          // Upstream end or outside framing is caught mid-bit
          if (tick_fall && (fe_sync_reg[1] || fs_sync_reg[1])) begin
            start_pend_reg <= 1'b1;
          end
          if (!ctl_en || ctl_master) begin
            state_reg <= tsoc_pkg::ST_IDLE;
          end else if (tick_rise && start_pend_reg) begin
            start_pend_reg <= 1'b0;
            o_serial_data_out_line_oe <= 1'b1;
            o_serial_data_out_line <= sh_reg[SH_W-1];
            sh_reg <= {sh_reg[SH_W-2:0], 1'b0};
            bitcnt_reg <= CNT_W'(1);
            state_reg <= tsoc_pkg::ST_SHIFT;
          end
        end
        tsoc_pkg::ST_SHIFT: begin
          if (tick_rise) begin
            if (bitcnt_reg == total_reg) begin
              // Share finished: release the line
              o_serial_data_out_line_oe <= 1'b0;
              o_serial_data_out_line <= 1'b0;
              o_frame_end_strobe <= 1'b0;
              loaded_reg <= 1'b0;
              state_reg <= tsoc_pkg::ST_IDLE;
            end else begin
              o_serial_data_out_line <= sh_reg[SH_W-1];
              sh_reg <= {sh_reg[SH_W-2:0], 1'b0};
              bitcnt_reg <= bitcnt_reg + CNT_W'(1);
              o_frame_end_strobe <= (bitcnt_reg + CNT_W'(1) == total_reg);
            end
          end
        end
        default: begin
          state_reg <= tsoc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt events; set beats a clear in the same cycle
  assign irq_ev[tsoc_pkg::IRQ_LOADED_BIT] = load;
  assign irq_ev[tsoc_pkg::IRQ_DONE_BIT] = frame_done;
  assign irq_ev[tsoc_pkg::IRQ_OVERRUN_BIT] = i_sample_valid & ctl_en & loaded_reg;

  assign access = i_psel & i_penable & ~o_pready;
  assign wr = access & i_pwrite;
  assign rd = access & ~i_pwrite;
  assign addr_ok = (i_paddr == tsoc_pkg::CTRL_OFS) || (i_paddr == tsoc_pkg::STATUS_OFS) ||
                   (i_paddr == tsoc_pkg::IRQ_STAT_OFS) || (i_paddr == tsoc_pkg::IRQ_CLR_OFS) ||
                   (i_paddr == tsoc_pkg::IRQ_EN_OFS);
  assign irq_clr = (wr && i_paddr == tsoc_pkg::IRQ_CLR_OFS) ? i_pwdata[tsoc_pkg::N_IRQ-1:0] : '0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_stat_reg <= tsoc_pkg::IRQ_RST;
      o_irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= tsoc_pkg::CTRL_RST;
      irq_en_reg <= tsoc_pkg::IRQ_RST;
    end else if (wr) begin
      if (i_paddr == tsoc_pkg::CTRL_OFS) begin
        ctrl_reg <= i_pwdata[tsoc_pkg::CTRL_W-1:0];
      end
      if (i_paddr == tsoc_pkg::IRQ_EN_OFS) begin
        irq_en_reg <= i_pwdata[tsoc_pkg::N_IRQ-1:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (i_paddr)
      tsoc_pkg::CTRL_OFS: rd_mux[tsoc_pkg::CTRL_W-1:0] = ctrl_reg;
      tsoc_pkg::STATUS_OFS: begin
        rd_mux[tsoc_pkg::STAT_STATE_LSB +: 2] = state_reg;
        rd_mux[tsoc_pkg::STAT_LOADED_BIT] = loaded_reg;
        rd_mux[tsoc_pkg::STAT_OWN_BIT] = o_serial_data_out_line_oe;
        rd_mux[tsoc_pkg::STAT_BUS_MASTER_BIT] = bm_sync_reg[1];
        rd_mux[tsoc_pkg::STAT_APPEND_PEND_BIT] = app_pend_reg;
      end
      tsoc_pkg::IRQ_STAT_OFS: rd_mux[tsoc_pkg::N_IRQ-1:0] = irq_stat_reg;
      tsoc_pkg::IRQ_EN_OFS: rd_mux[tsoc_pkg::N_IRQ-1:0] = irq_en_reg;
      default: rd_mux = 32'h0;
    endcase
  end

  // One wait state keeps pready and prdata straight from flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      o_pready <= access;
      o_pslverr <= access & ~addr_ok;
      o_prdata <= rd ? rd_mux : 32'h0;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/tsoc_sclk_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsoc_sclk_gen #(
  parameter int DIV_W = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_gen_en,
  input wire logic [DIV_W-1:0] i_div,
  input wire logic i_ext_sclk,
  output logic o_sclk,
  output logic o_tick_rise,
  output logic o_tick_fall
);

  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] half;

  // Zero gives half the clock, otherwise clock over twice the word
  assign half = (i_div == '0) ? DIV_W'(1) : i_div;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= i_ext_sclk;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
      o_sclk <= 1'b0;
      o_tick_rise <= 1'b0;
      o_tick_fall <= 1'b0;
    end else if (i_gen_en) begin
      if (cnt_reg >= half - DIV_W'(1)) begin
        cnt_reg <= '0;
        o_sclk <= ~o_sclk;
        o_tick_rise <= ~o_sclk;
        o_tick_fall <= o_sclk;
      end else begin
        cnt_reg <= cnt_reg + DIV_W'(1);
        o_tick_rise <= 1'b0;
        o_tick_fall <= 1'b0;
      end
    end else begin
      // Divider word ignored, edges come from the outside clock
      cnt_reg <= '0;
      o_sclk <= 1'b0;
      o_tick_rise <= ext_sync_reg & ~ext_prev_reg;
      o_tick_fall <= ~ext_sync_reg & ext_prev_reg;
    end
  end

endmodule
`default_nettype wire
